// ### hw/geu_map.svh
/*
 * register offsets, reset values and the pin count of the event-driven
 * digital output block. assumes an 8-bit register address space and 8 pins.
 */
`ifndef GEU_MAP_SVH
`define GEU_MAP_SVH

`define GEU_CH 8
`define GEU_A_ZC_LEVEL_LO 8'he3
`define GEU_A_ZC_LEVEL_HI 8'he4
`define GEU_A_ZC_EN 8'he7
`define GEU_A_ALERT_EN 8'he9
`define GEU_A_ALERT_VAL 8'heb
`define GEU_A_IO_DIR 8'h03
`define GEU_A_DRIVE 8'h04
`define GEU_A_PIN_FUNC 8'h05
`define GEU_A_OUT_LEVEL 8'h0b
`define GEU_A_IN_LEVEL 8'h0d
`define GEU_A_MASK_BASE 8'hc3
`define GEU_RST_REG 8'h00
`define GEU_RST_CODE 16'h0000
`define GEU_RST_MASK 64'h0
`define GEU_RST_OE_N 8'hff

`endif

// ### hw/geu_pkg.sv
/*
 * types shared by the event-driven digital output block.
 * assumes geu_map.svh for widths and offsets.
 */
`include "geu_map.svh"
package geu_pkg;
    // pin function, decoded from the three config registers
    typedef enum logic [1:0] {
        GEU_PIN_ANALOG = 2'b00,
        GEU_PIN_INPUT = 2'b01,
        GEU_PIN_OD = 2'b10,
        GEU_PIN_PP = 2'b11
    } geu_pin_e;

    // register port request, one cycle per access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } geu_req_s;

    // whole state of the block
    typedef struct packed {
        logic [7:0] zc_en;
        logic [15:0] zc_code;
        logic [7:0] alert_en;
        logic [7:0] alert_val;
        logic [63:0] mask;
        logic [7:0] pin_func;
        logic [7:0] io_dir;
        logic [7:0] drive;
        logic [7:0] level;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_s3;
        logic [7:0] pin_in;
        logic zc_prev;
        logic [7:0] hit_prev;
        logic [7:0] pin_out;
        logic [7:0] pin_oe_n;
        logic [7:0] rd_data;
    } geu_state_s;
endpackage

// ### hw/geu_top.sv
/*
 * event-driven digital output and pin configuration logic for eight pins.
 * assumes zero_cross_in and alert_flags come from logic on the same clock;
 * pin_in comes from the pads and is synchronised here. the pad cell works
 * out the wire level from pin_out and pin_oe_n.
 */
`timescale 1ns/1ps
`include "geu_map.svh"
module geu_top
    import geu_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire geu_req_s req,
    input wire logic zero_cross_in,
    input wire logic [7:0] alert_flags,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] reg_rdata
);
    localparam geu_state_s ST_RST = '{
        zc_en: `GEU_RST_REG, zc_code: `GEU_RST_CODE, alert_en: `GEU_RST_REG,
        alert_val: `GEU_RST_REG, mask: `GEU_RST_MASK, pin_func: `GEU_RST_REG,
        io_dir: `GEU_RST_REG, drive: `GEU_RST_REG, level: `GEU_RST_REG,
        pin_s1: `GEU_RST_REG, pin_s2: `GEU_RST_REG, pin_s3: `GEU_RST_REG,
        pin_in: `GEU_RST_REG, zc_prev: 1'b0, hit_prev: `GEU_RST_REG,
        pin_out: `GEU_RST_REG, pin_oe_n: `GEU_RST_OE_N, rd_data: `GEU_RST_REG};

    logic [1:0] rst_sync_q; // reset release pipeline
    logic rst_n_q; // synchronised reset used everywhere else
    geu_state_s q; // registered state
    geu_state_s d; // next state
    logic zc_edge; // crossing signal changed this cycle
    logic sw_wr_level; // software writes the output level
    logic [7:0] zc_target; // level each zc_en output takes on this crossing, unless its alert fires
    logic [7:0] hit; // a selected alert flag is set
    logic [7:0] alert_fire; // alert update happens this cycle
    logic [7:0] drv_out; // next pad data
    logic [7:0] drv_oe_n; // next pad enable, low drives
    logic [7:0] od_pins; // pins in open-drain mode
    logic [7:0] pp_pins; // pins in push-pull mode
    logic [7:0] out_pins; // pins that may drive at all
    logic [7:0] in_pins; // pins read as digital inputs

    // reset release, asynchronous assert and clocked release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_q = rst_sync_q[1];

    assign zc_edge = zero_cross_in != q.zc_prev;
    assign sw_wr_level = req.wr && req.addr == `GEU_A_OUT_LEVEL;
    // only a newly set flag fires, so a flag that stays up loads once
    assign alert_fire = q.alert_en & hit & ~q.hit_prev;

    // per-channel event targets and pad decode
    for (genvar i = 0; i < `GEU_CH; i++) begin : g_ch
        geu_pin_e mode;
        // rising edge launches the high code bit, falling the low bit
        assign zc_target[i] = zero_cross_in ? q.zc_code[2*i+1] : q.zc_code[2*i];
        assign hit[i] = |(alert_flags & q.mask[8*i +: 8]);
        // function first, then direction, then drive type
        assign mode = !q.pin_func[i] ? GEU_PIN_ANALOG :
                      !q.io_dir[i] ? GEU_PIN_INPUT :
                      q.drive[i] ? GEU_PIN_PP : GEU_PIN_OD;
        assign od_pins[i] = mode == GEU_PIN_OD;
        assign pp_pins[i] = mode == GEU_PIN_PP;
        assign out_pins[i] = od_pins[i] | pp_pins[i];
        assign in_pins[i] = mode == GEU_PIN_INPUT;
        // pad drive per mode
        always_comb begin
            unique case (mode)
                GEU_PIN_ANALOG, GEU_PIN_INPUT: begin
                    drv_out[i] = 1'b0;
                    drv_oe_n[i] = 1'b1;
                end
                GEU_PIN_OD: begin
                    // high level releases the pin to the pull-up
                    drv_out[i] = 1'b0;
                    drv_oe_n[i] = q.level[i];
                end
                GEU_PIN_PP: begin
                    drv_out[i] = q.level[i];
                    drv_oe_n[i] = 1'b0;
                end
            endcase
        end
    end

    // next state: register writes, events, pads and readback
    always_comb begin
        d = q;
        d.pin_s1 = pin_in;
        d.pin_s2 = q.pin_s1;
        d.pin_s3 = q.pin_s2;
        // a bit only changes once the second and third stages agree
        d.pin_in = (q.pin_s3 & ~(q.pin_s2 ^ q.pin_s3)) | (q.pin_in & (q.pin_s2 ^ q.pin_s3));
        d.zc_prev = zero_cross_in;
        d.hit_prev = hit;
        if (req.wr) begin
            unique case (req.addr)
                `GEU_A_ZC_LEVEL_LO: d.zc_code[7:0] = req.wdata;
                `GEU_A_ZC_LEVEL_HI: d.zc_code[15:8] = req.wdata;
                `GEU_A_ZC_EN: d.zc_en = req.wdata;
                `GEU_A_ALERT_EN: d.alert_en = req.wdata;
                `GEU_A_ALERT_VAL: d.alert_val = req.wdata;
                `GEU_A_IO_DIR: d.io_dir = req.wdata;
                `GEU_A_DRIVE: d.drive = req.wdata;
                `GEU_A_PIN_FUNC: d.pin_func = req.wdata;
                `GEU_A_OUT_LEVEL: d.level = req.wdata;
                default: begin
                    // mask block; other addresses ignored
                    for (int m = 0; m < `GEU_CH; m++) begin
                        if (req.addr == `GEU_A_MASK_BASE + 8'(m)) begin
                            d.mask[8*m +: 8] = req.wdata;
                        end
                    end
                end
            endcase
        end
        // events win over a software level write in the same cycle
        for (int c = 0; c < `GEU_CH; c++) begin
            if (zc_edge && q.zc_en[c]) begin
                d.level[c] = zc_target[c];
            end
            if (alert_fire[c]) begin
                d.level[c] = q.alert_val[c];
            end
        end
        d.pin_out = drv_out;
        d.pin_oe_n = drv_oe_n;
        d.rd_data = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                `GEU_A_ZC_LEVEL_LO: d.rd_data = q.zc_code[7:0];
                `GEU_A_ZC_LEVEL_HI: d.rd_data = q.zc_code[15:8];
                `GEU_A_ZC_EN: d.rd_data = q.zc_en;
                `GEU_A_ALERT_EN: d.rd_data = q.alert_en;
                `GEU_A_ALERT_VAL: d.rd_data = q.alert_val;
                `GEU_A_IO_DIR: d.rd_data = q.io_dir;
                `GEU_A_DRIVE: d.rd_data = q.drive;
                `GEU_A_PIN_FUNC: d.rd_data = q.pin_func;
                `GEU_A_OUT_LEVEL: d.rd_data = q.level;
                `GEU_A_IN_LEVEL: d.rd_data = q.pin_in & in_pins;
                default: begin
                    // mask readback; unmapped reads return zero
                    for (int r = 0; r < `GEU_CH; r++) begin
                        if (req.addr == `GEU_A_MASK_BASE + 8'(r)) begin
                            d.rd_data = q.mask[8*r +: 8];
                        end
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign pin_out = q.pin_out;
    assign pin_oe_n = q.pin_oe_n;
    assign reg_rdata = q.rd_data;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n_q);

    sequence s_zc_step;
        zc_edge && !sw_wr_level && alert_fire == 8'h00;
    endsequence
    sequence s_read_in;
        req.rd && req.addr == `GEU_A_IN_LEVEL;
    endsequence

    chk_zc_disabled_hold: assert property (
        zc_edge && !sw_wr_level |=>
        ((q.level ^ $past(q.level)) & ~$past(q.zc_en) & ~$past(alert_fire)) == 8'h00)
        else $error("output moved on crossing while not enabled");
    chk_zc_level_code: assert property (
        s_zc_step |=> (q.level & $past(q.zc_en)) == ($past(zc_target) & $past(q.zc_en)))
        else $error("crossing level does not match code");
    chk_alert_gated: assert property (
        !zc_edge && !sw_wr_level |=> ((q.level ^ $past(q.level)) & ~$past(alert_fire)) == 8'h00)
        else $error("output moved without enabled alert");
    // judged on the level itself, so a broken mask decode cannot hide behind alert_fire
    chk_alert_mask_src: assert property (
        !zc_edge && !sw_wr_level && alert_flags == 8'h00 |=> $stable(q.level))
        else $error("alert fired without selected flag");
    chk_alert_load_val: assert property (
        alert_fire != 8'h00 && !sw_wr_level |=>
        (q.level & $past(alert_fire)) == ($past(q.alert_val) & $past(alert_fire)))
        else $error("alert update loaded wrong level");
    chk_trig_val_idle: assert property (
        !zc_edge && !sw_wr_level |=>
        ((q.level ^ $past(q.level)) & ~$past(q.alert_en)) == 8'h00)
        else $error("trigger value used while alert updates off");
    chk_pin_release: assert property (
        ##1 (~q.pin_oe_n & ~$past(out_pins)) == 8'h00)
        else $error("non-output pin driven");
    chk_input_read: assert property (
        s_read_in |=> reg_rdata == ($past(q.pin_in) & $past(in_pins)))
        else $error("input level readback wrong");
    chk_od_drive: assert property (
        ##1 (((q.pin_oe_n ^ $past(q.level)) | q.pin_out) & $past(od_pins)) == 8'h00)
        else $error("open-drain pin not low-or-released");
    chk_pp_drive: assert property (
        ##1 ((q.pin_oe_n | (q.pin_out ^ $past(q.level))) & $past(pp_pins)) == 8'h00)
        else $error("push-pull pin not driven to level");
    chk_level_hold: assert property (
        !zc_edge && alert_fire == 8'h00 && !req.wr |=> $stable(q.level))
        else $error("output level changed without cause");
endmodule

// ### verification/geu_pad_model.sv
/*
 * pad and board model for the eight pins: pull-ups plus an external source.
 * assumes pin_oe_n low means the block drives the pin.
 */
`timescale 1ns/1ps
module geu_pad_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    // resolved wire level, fed back to the pad inputs
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else begin
                pin_in[i] = 1'b1;
            end
        end
    end
endmodule

// ### verification/geu_top_tb.sv
/*
 * self-checking bench for the event-driven output block.
 * assumes geu_top and geu_pad_model; inputs move on the falling edge.
 */
`timescale 1ns/1ps
module geu_top_tb;
    import geu_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    geu_req_s req = '0;
    logic zero_cross_in = 1'b0;
    logic [7:0] alert_flags = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] pin_in, pin_out, pin_oe_n, reg_rdata;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    // 25 ns period
    always #12.5 clock = ~clock;
    geu_top dut (.clock(clock), .nrst(nrst), .req(req), .zero_cross_in(zero_cross_in),
        .alert_flags(alert_flags), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .reg_rdata(reg_rdata));
    geu_pad_model pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // cut a hang short well past the expected hundred or so cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clock);
        req.wr = 1'b0;
    endtask
    // read data stands one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        req.rd = 1'b0;
        chk(reg_rdata, exp);
    endtask
    // two cycles from cause to pins, one spare
    task automatic pins(input logic [7:0] o, input logic [7:0] oe);
        repeat (3) @(negedge clock);
        chk(pin_out, o);
        chk(pin_oe_n, oe);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        // reset values of the event enable and alert value registers, then the pads
        rd(8'he7, 8'h00);
        rd(8'he9, 8'h00);
        rd(8'heb, 8'h00);
        pins(8'h00, 8'hff);
        $display("test 1 done");
        // all digital outputs; low nibble push-pull, high nibble open-drain
        wr(8'h05, 8'hff);
        wr(8'h03, 8'hff);
        wr(8'h04, 8'h0f);
        wr(8'h0b, 8'ha5);
        pins(8'h05, 8'ha0);
        $display("test 2 done");
        // crossing on outputs 0..3, codes 00 01 10 11
        wr(8'he3, 8'he4);
        wr(8'he4, 8'h00);
        wr(8'he7, 8'h0f);
        zero_cross_in = 1'b1;
        pins(8'h0c, 8'ha0);
        zero_cross_in = 1'b0;
        pins(8'h0a, 8'ha0);
        $display("test 3 done");
        // alert on output 4 only, masks select alert flag 1
        wr(8'hc7, 8'h02);
        wr(8'hc8, 8'h02);
        wr(8'heb, 8'h10);
        wr(8'he9, 8'h10);
        alert_flags = 8'h01;
        pins(8'h0a, 8'ha0);
        alert_flags = 8'h03;
        pins(8'h0a, 8'hb0);
        wr(8'h0b, 8'ha5);
        pins(8'h05, 8'ha0);
        rd(8'he7, 8'h0f);
        rd(8'he9, 8'h10);
        rd(8'heb, 8'h10);
        $display("test 4 done");
        // crossing wins over a level write in the same cycle
        @(negedge clock);
        req = '{wr: 1'b1, rd: 1'b0, addr: 8'h0b, wdata: 8'h50};
        zero_cross_in = 1'b1;
        @(negedge clock);
        req.wr = 1'b0;
        pins(8'h0c, 8'h50);
        // falling crossing with outputs disabled, then the level is rewritten to a5
        wr(8'he7, 8'h00);
        zero_cross_in = 1'b0;
        wr(8'h0b, 8'ha5);
        pins(8'h05, 8'ha0);
        $display("test 5 done");
        // high nibble as inputs driven from outside
        ext_val = 8'h90;
        ext_en = 8'hf0;
        wr(8'h03, 8'h0f);
        pins(8'h05, 8'hf0);
        repeat (6) @(negedge clock);
        rd(8'h0d, 8'h90);
        wr(8'h0d, 8'hff);
        rd(8'h0d, 8'h90);
        rd(8'h80, 8'h00);
        $display("test 6 done");
        stop_test();
    end
endmodule
